// ### design/ubt_top.sv
`timescale 1ns/1ps
// Function
// - Full-duplex serial port, frame modes one/three
// - Receive shifter separate from receive buffer
// - Data writes always load transmit register
// - Data reads return receive buffer only
// - Done flags raise interrupt when enabled
// - Done flags cleared only by software write
// - Transmit clock from 8-bit auto-reload counter
// - Hidden receive counter, same reload, timer-enabled
// - Both overflow streams halved into baud
// - Start edge forces receive counter reload
// - Six selectable timer clock sources
// - 8-bit frame: start, eight LSB-first, stop
// - 9-bit frame adds chosen ninth bit
// - Transmit done set at stop-bit start
module ubt_top
	import ubt_pkg::*;
(
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        SYS_RST,
	// Avalon-MM slave
	input  wire logic [4:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	output logic      [31:0] AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	// Serial line and timer clock pins
	input  wire logic        RXD,
	output logic             TXD,
	input  wire logic        EXT_OSC,
	input  wire logic        TMR_PIN,
	// Interrupt
	output logic             IRQ
);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [1:0] rxd_s_q;
	logic [1:0] osc_s_q;
	logic [1:0] pin_s_q;
	logic       osc_prev_q;
	logic       pin_prev_q;
	logic       rxd_prev_q;

	// Two stages each; only stage 1 feeds logic
	always_ff @(posedge CLK) begin
		rxd_s_q    <= {rxd_s_q[0], RXD};
		osc_s_q    <= {osc_s_q[0], EXT_OSC};
		pin_s_q    <= {pin_s_q[0], TMR_PIN};
		rxd_prev_q <= rxd_s_q[1];
		osc_prev_q <= osc_s_q[1];
		pin_prev_q <= pin_s_q[1];
	end

	wire rxd_in   = rxd_s_q[1];
	wire osc_rise = osc_s_q[1] & ~osc_prev_q;
	wire pin_rise = pin_s_q[1] & ~pin_prev_q;

	// ------------------------------------------------------------
	// Bus handshake and decode
	// ------------------------------------------------------------
	logic       wait_q;
	logic [31:0] rdata_q;
	wire        req     = AVS_READ | AVS_WRITE;
	wire        accept  = req & ~wait_q;
	wire        wr_en   = accept & AVS_WRITE & AVS_BYTEENABLE[0];
	wire        wr_ctrl = wr_en & (AVS_ADDRESS == ADDR_CTRL);
	wire        wr_data = wr_en & (AVS_ADDRESS == ADDR_DATA);
	wire        wr_tmr  = wr_en & (AVS_ADDRESS == ADDR_TMR_CTRL);
	wire        wr_rld  = wr_en & (AVS_ADDRESS == ADDR_RELOAD);
	wire        wr_stat = wr_en & (AVS_ADDRESS == ADDR_STATUS);
	wire        wr_mask = wr_en & (AVS_ADDRESS == ADDR_MASK);
	wire [7:0]  wbyte   = AVS_WRITEDATA[7:0];

	// Fixed one wait cycle: request seen, then answered
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			wait_q <= 1'b1;
		end else begin
			wait_q <= ~(req & wait_q);
		end
	end

	// ------------------------------------------------------------
	// Software-visible state
	// ------------------------------------------------------------
	ubt_ctrl_type   ctrl_q;
	logic           tmr_en_q;
	ubt_clksel_type sel_q;
	logic [7:0]     reload_q;
	logic [1:0]     mask_q;
	logic           ti_q;
	logic           ri_q;
	logic [7:0]     rbuf_q;
	logic [7:0]     thold_q;
	logic           tpend_q;
	logic           ti_set;
	logic           ri_set;
	logic           rb8_set;
	logic           rb8_val;

	// Configuration writes
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			ctrl_q   <= '0;
			tmr_en_q <= 1'b0;
			sel_q    <= SEL_SYS;
			reload_q <= RELOAD_RST;
			mask_q   <= '0;
		end else begin
			if (wr_ctrl) begin
				ctrl_q.mode9    <= wbyte[CTRL_MODE9_BIT];
				ctrl_q.mce      <= wbyte[CTRL_MCE_BIT];
				ctrl_q.rx_en    <= wbyte[CTRL_REN_BIT];
				ctrl_q.tx_ninth <= wbyte[CTRL_TB8_BIT];
			end
			// Hardware capture wins over a same-cycle write
			if (rb8_set) begin
				ctrl_q.rx_ninth <= rb8_val;
			end else if (wr_ctrl) begin
				ctrl_q.rx_ninth <= wbyte[CTRL_RB8_BIT];
			end
			if (wr_tmr) begin
				tmr_en_q <= wbyte[TMR_EN_BIT];
				sel_q    <= ubt_clksel_type'(
					wbyte[TMR_SEL_MSB:TMR_SEL_LSB]);
			end
			if (wr_rld) begin
				reload_q <= wbyte;
			end
			if (wr_mask) begin
				mask_q <= wbyte[STAT_TI_BIT:STAT_RI_BIT];
			end
		end
	end

	// Sticky done flags, set beats write-one-clear
	wire ti_clr = wr_stat & wbyte[STAT_TI_BIT];
	wire ri_clr = wr_stat & wbyte[STAT_RI_BIT];
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			ti_q <= 1'b0;
			ri_q <= 1'b0;
		end else begin
			ti_q <= ti_set | (ti_q & ~ti_clr);
			ri_q <= ri_set | (ri_q & ~ri_clr);
		end
	end

	// Interrupt level from unmasked flags
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |({ti_set | ti_q, ri_set | ri_q} & mask_q);
		end
	end

	// ------------------------------------------------------------
	// Timer clock prescaler
	// ------------------------------------------------------------
	logic [5:0] div4_q;
	logic [5:0] div12_q;
	logic [5:0] div48_q;
	logic [2:0] ext8_q;

	// Free-running dividers; phase versus enable is not aligned
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			div4_q  <= '0;
			div12_q <= '0;
			div48_q <= '0;
			ext8_q  <= '0;
		end else begin
			div4_q  <= (div4_q == DIV4_LAST) ? '0 : div4_q + 6'h01;
			div12_q <= (div12_q == DIV12_LAST) ? '0 : div12_q + 6'h01;
			div48_q <= (div48_q == DIV48_LAST) ? '0 : div48_q + 6'h01;
			if (osc_rise) begin
				ext8_q <= ext8_q + 3'h1;
			end
		end
	end

	// Source selection, one tick per timer clock
	wire tmr_tick = tmr_en_q & (
		(sel_q == SEL_SYS)   ? 1'b1 :
		(sel_q == SEL_DIV4)  ? (div4_q == DIV4_LAST) :
		(sel_q == SEL_DIV12) ? (div12_q == DIV12_LAST) :
		(sel_q == SEL_DIV48) ? (div48_q == DIV48_LAST) :
		(sel_q == SEL_EXT8)  ? (osc_rise & (ext8_q == EXT8_LAST)) :
		(sel_q == SEL_PIN)   ? pin_rise : 1'b0);

	// ------------------------------------------------------------
	// Baud counters
	// ------------------------------------------------------------
	logic [7:0] tx_cnt_q;
	logic [7:0] rx_cnt_q;
	logic       tx_half_q;
	logic       rx_half_q;
	ubt_state_type tx_st_q;
	ubt_state_type rx_st_q;

	wire start_det = (rx_st_q == ST_IDLE) & ctrl_q.rx_en & tmr_en_q &
		rxd_prev_q & ~rxd_in;
	wire tx_ovf    = tmr_tick & (tx_cnt_q == CNT_TOP);
	wire rx_ovf    = tmr_tick & (rx_cnt_q == CNT_TOP) & ~start_det;
	wire tx_baud   = tx_ovf & tx_half_q;
	wire rx_sample = rx_ovf & ~rx_half_q;

	// Auto-reload counters; receive copy realigns on start edge
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			tx_cnt_q  <= RELOAD_RST;
			rx_cnt_q  <= RELOAD_RST;
			tx_half_q <= 1'b0;
			rx_half_q <= 1'b0;
		end else begin
			if (tmr_tick) begin
				tx_cnt_q <= tx_ovf ? reload_q : tx_cnt_q + 8'h01;
			end
			if (start_det) begin
				rx_cnt_q  <= reload_q;
				rx_half_q <= 1'b0;
			end else if (tmr_tick) begin
				rx_cnt_q <= rx_ovf ? reload_q : rx_cnt_q + 8'h01;
			end
			if (tx_ovf) begin
				tx_half_q <= ~tx_half_q;
			end
			if (rx_ovf) begin
				rx_half_q <= ~rx_half_q;
			end
		end
	end

	// ------------------------------------------------------------
	// Transmitter
	// ------------------------------------------------------------
	logic [7:0] tx_sh_q;
	logic [2:0] tx_bit_q;
	assign ti_set = tx_baud & (((tx_st_q == ST_DATA) &
		(tx_bit_q == DATA_LAST) & ~ctrl_q.mode9) |
		(tx_st_q == ST_NINTH));

	// Each write loads the holding byte and requests a frame
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			thold_q <= '0;
			tpend_q <= 1'b0;
		end else if (wr_data) begin
			thold_q <= wbyte;
			tpend_q <= 1'b1;
		end else if (tx_baud & (tx_st_q == ST_IDLE)) begin
			tpend_q <= 1'b0;
		end
	end

	// Frame sequencer, one step per transmit bit time
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			tx_st_q  <= ST_IDLE;
			tx_sh_q  <= '0;
			tx_bit_q <= '0;
			TXD      <= 1'b1;
		end else if (tx_baud) begin
			unique case (tx_st_q)
				ST_IDLE: if (tpend_q) begin
					tx_st_q <= ST_START;
					tx_sh_q <= thold_q;
					TXD     <= 1'b0;
				end
				ST_START: begin
					tx_st_q  <= ST_DATA;
					tx_bit_q <= '0;
					TXD      <= tx_sh_q[0];
					tx_sh_q  <= tx_sh_q >> 1;
				end
				ST_DATA: if (tx_bit_q != DATA_LAST) begin
					tx_bit_q <= tx_bit_q + 3'h1;
					TXD      <= tx_sh_q[0];
					tx_sh_q  <= tx_sh_q >> 1;
				end else if (ctrl_q.mode9) begin
					tx_st_q <= ST_NINTH;
					TXD     <= ctrl_q.tx_ninth;
				end else begin
					tx_st_q <= ST_STOP;
					TXD     <= 1'b1;
				end
				ST_NINTH: begin
					tx_st_q <= ST_STOP;
					TXD     <= 1'b1;
				end
				ST_STOP: tx_st_q <= ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Receiver
	// ------------------------------------------------------------
	logic [7:0] rx_sh_q;
	logic [2:0] rx_bit_q;
	logic       rx9_q;
	// 8-bit mode qualifies on stop bit, 9-bit on ninth
	wire rx_qual  = ctrl_q.mode9 ? rx9_q : rxd_in;
	wire rx_end   = rx_sample & (rx_st_q == ST_STOP);
	wire rx_store = rx_end & ~ri_q & (~ctrl_q.mce | rx_qual);
	assign ri_set  = rx_store;
	assign rb8_set = rx_store;
	assign rb8_val = rx_qual;

	// Shifter is apart from the buffer, so a new frame may start
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			rx_st_q  <= ST_IDLE;
			rx_sh_q  <= '0;
			rx_bit_q <= '0;
			rx9_q    <= 1'b0;
			rbuf_q   <= '0;
		end else begin
			if (rx_store) begin
				rbuf_q <= rx_sh_q;
			end
			unique case (rx_st_q)
				ST_IDLE: if (start_det) begin
					rx_st_q <= ST_START;
				end
				ST_START: if (rx_sample) begin
					// A glitch that is high mid-bit is no start
					rx_st_q  <= rxd_in ? ST_IDLE : ST_DATA;
					rx_bit_q <= '0;
				end
				ST_DATA: if (rx_sample) begin
					rx_sh_q  <= {rxd_in, rx_sh_q[7:1]};
					rx_bit_q <= rx_bit_q + 3'h1;
					if (rx_bit_q == DATA_LAST) begin
						rx_st_q <= ctrl_q.mode9 ? ST_NINTH : ST_STOP;
					end
				end
				ST_NINTH: if (rx_sample) begin
					rx9_q   <= rxd_in;
					rx_st_q <= ST_STOP;
				end
				ST_STOP: if (rx_sample) begin
					rx_st_q <= ST_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	wire [7:0] ctrl_rd = {ctrl_q.mode9, 1'b1, ctrl_q.mce, ctrl_q.rx_en,
		ctrl_q.tx_ninth, ctrl_q.rx_ninth, ti_q, ri_q};
	wire [7:0] rd_mux =
		(AVS_ADDRESS == ADDR_CTRL)     ? ctrl_rd :
		(AVS_ADDRESS == ADDR_DATA)     ? rbuf_q :
		(AVS_ADDRESS == ADDR_TMR_CTRL) ? {4'h0, sel_q, tmr_en_q} :
		(AVS_ADDRESS == ADDR_RELOAD)   ? reload_q :
		(AVS_ADDRESS == ADDR_STATUS)   ? {6'h00, ti_q, ri_q} :
		(AVS_ADDRESS == ADDR_MASK)     ? {6'h00, mask_q} :
		(AVS_ADDRESS == ADDR_TMR_LOW)  ? tx_cnt_q : 8'h00;

	// Read data captured in the wait cycle, held through the answer
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			rdata_q <= '0;
		end else if (req & wait_q & AVS_READ) begin
			rdata_q <= {24'h000000, rd_mux};
		end
	end

	assign AVS_READDATA    = rdata_q;
	assign AVS_WAITREQUEST = wait_q;

endmodule

// ### design/ubt_pkg.sv
package ubt_pkg;

	// ------------------------------------------------------------
	// Clock
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ = 25_000_000;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [4:0] ADDR_CTRL     = 5'h00;
	localparam logic [4:0] ADDR_DATA     = 5'h04;
	localparam logic [4:0] ADDR_TMR_CTRL = 5'h08;
	localparam logic [4:0] ADDR_RELOAD   = 5'h0C;
	localparam logic [4:0] ADDR_STATUS   = 5'h10;
	localparam logic [4:0] ADDR_MASK     = 5'h14;
	localparam logic [4:0] ADDR_TMR_LOW  = 5'h18;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CTRL_MODE9_BIT = 7;
	localparam int CTRL_ONE_BIT   = 6;
	localparam int CTRL_MCE_BIT   = 5;
	localparam int CTRL_REN_BIT   = 4;
	localparam int CTRL_TB8_BIT   = 3;
	localparam int CTRL_RB8_BIT   = 2;
	localparam int CTRL_TI_BIT    = 1;
	localparam int CTRL_RI_BIT    = 0;
	localparam int STAT_RI_BIT    = 0;
	localparam int STAT_TI_BIT    = 1;
	localparam int TMR_EN_BIT     = 0;
	localparam int TMR_SEL_LSB    = 1;
	localparam int TMR_SEL_MSB    = 3;

	// ------------------------------------------------------------
	// Reset values and counts
	// ------------------------------------------------------------
	localparam logic [7:0] RELOAD_RST  = 8'h00;
	localparam logic [7:0] CNT_TOP     = 8'hFF;
	localparam logic [5:0] DIV4_LAST   = 6'h03;
	localparam logic [5:0] DIV12_LAST  = 6'h0B;
	localparam logic [5:0] DIV48_LAST  = 6'h2F;
	localparam logic [2:0] EXT8_LAST   = 3'h7;
	localparam logic [2:0] DATA_LAST   = 3'h7;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		SEL_SYS   = 3'h0,
		SEL_DIV4  = 3'h1,
		SEL_DIV12 = 3'h2,
		SEL_DIV48 = 3'h3,
		SEL_EXT8  = 3'h4,
		SEL_PIN   = 3'h5
	} ubt_clksel_type;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_START = 5'h02,
		ST_DATA  = 5'h04,
		ST_NINTH = 5'h08,
		ST_STOP  = 5'h10
	} ubt_state_type;

	typedef struct packed {
		logic mode9;
		logic mce;
		logic rx_en;
		logic tx_ninth;
		logic rx_ninth;
	} ubt_ctrl_type;

endpackage

// ### verification/ubt_sva.sv
`timescale 1ns/1ps
module ubt_sva
	import ubt_pkg::*;
(
	// Clock, reset, bus
	input wire logic        CLK,
	input wire logic        SYS_RST,
	input wire logic [4:0]  AVS_ADDRESS,
	input wire logic        AVS_READ,
	input wire logic        AVS_WRITE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic        AVS_WAITREQUEST,
	// Line and interrupt
	input wire logic        TXD,
	input wire logic        IRQ
);
	// ---
	// Checks
	// ---
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	// Request present, read accepted
	wire req = AVS_READ || AVS_WRITE;
	wire rok = AVS_READ && !AVS_WAITREQUEST;
	// Fresh request answered on the next edge
	sequence s_ack;
		req && AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
	endsequence
	chk_ack_next: assert property (
		req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("ack late");
	chk_ack_once: assert property (
		s_ack |=> AVS_WAITREQUEST)
		else $error("ack held too long");
	chk_ack_cause: assert property (
		$fell(AVS_WAITREQUEST) |-> $past(req))
		else $error("ack without request");
	chk_rdata_hold: assert property (
		!AVS_READ |=> $stable(AVS_READDATA))
		else $error("read data moved");
	chk_rd_upper: assert property (
		rok |-> AVS_READDATA[31:8] == 24'h000000)
		else $error("upper read bits set");
	chk_unmap_zero: assert property (
		rok && AVS_ADDRESS > ADDR_TMR_LOW |-> AVS_READDATA == 32'h0)
		else $error("unmapped read not zero");
	chk_ctrl_one: assert property (
		rok && AVS_ADDRESS == ADDR_CTRL |-> AVS_READDATA[CTRL_ONE_BIT])
		else $error("fixed control bit low");
	chk_irq_clear: assert property (
		$fell(IRQ) |-> $past(AVS_WRITE) || $past(AVS_WRITE, 2))
		else $error("interrupt dropped by itself");
	chk_start_min: assert property (
		$fell(TXD) |=> !TXD)
		else $error("start bit too short");
endmodule

// ### verification/ubt_peer.sv
`timescale 1ns/1ps
module ubt_peer (
	// Line side
	input  wire logic clk,
	input  wire logic txd,
	output logic      rxd
);
	// ---
	// Remote serial device
	// ---
	// Line idles high as if pulled up
	initial rxd = 1'h1;
	// One frame, LSB first; stop bit leaves the line idle
	task automatic send(input logic [8:0] d, input logic nine,
		input int bc);
		logic [10:0] f;
		f = nine ? {1'h1, d, 1'h0} : {2'h3, d[7:0], 1'h0};
		for (int i = 0; i < 10 + nine; i++) begin
			rxd <= f[i];
			repeat (bc) @(posedge clk);
		end
	endtask
	// Sample each cell mid-bit after the start fall
	task automatic recv(input int bc, input int n,
		output logic [10:0] f, output logic ok);
		int t;
		f = '0;
		for (t = 0; t < 4000 && txd === 1'h1; t++) @(posedge clk);
		ok = (txd === 1'h0);
		repeat (bc / 2) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			f[i] = txd;
			repeat (bc) @(posedge clk);
		end
	endtask
endmodule

// ### verification/ubt_test.sv
`timescale 1ns/1ps
module ubt_test
	import ubt_pkg::*;
;
	// ---
	// Bench signals
	// ---
	localparam int bit_clks = 32;
	logic        CLK = 1'h0;
	logic        SYS_RST = 1'h1;
	logic [4:0]  AVS_ADDRESS = 5'h00;
	logic        AVS_READ = 1'h0;
	logic        AVS_WRITE = 1'h0;
	logic [31:0] AVS_WRITEDATA = 32'h0;
	logic [31:0] AVS_READDATA;
	logic        AVS_WAITREQUEST;
	logic        RXD;
	logic        TXD;
	logic        EXT_OSC = 1'h0;
	logic        TMR_PIN = 1'h0;
	logic        IRQ;
	int          fail_count = 0;
	int          n_compared = 0;
	int          divs[6] = '{1, 4, 12, 48, 16, 2};
	logic [31:0] rd;
	logic [10:0] fr;
	logic        ok;
	logic [7:0]  b0;
	logic [7:0]  b1;
	// Clock and free-running external tick sources
	always #20 CLK = ~CLK;
	always @(posedge CLK) begin
		EXT_OSC <= ~EXT_OSC;
		TMR_PIN <= ~TMR_PIN;
	end
	ubt_top DUT (
		.CLK(CLK), .SYS_RST(SYS_RST), .AVS_ADDRESS(AVS_ADDRESS),
		.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
		.AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hF),
		.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
		.RXD(RXD), .TXD(TXD), .EXT_OSC(EXT_OSC), .TMR_PIN(TMR_PIN),
		.IRQ(IRQ)
	);
	ubt_peer u_peer (.clk(CLK), .txd(TXD), .rxd(RXD));
	// ---
	// Tasks
	// ---
	task automatic tally_and_finish();
		if (fail_count == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic hang();
		fail_count++;
		tally_and_finish();
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h want %h", $time, seen, exp);
		end
	endtask
	// Held until waitrequest samples low; an idle edge avoids re-driving
	task automatic bus(input logic w, input logic [4:0] a,
		input logic [7:0] d);
		int t;
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= {24'h0, d};
		AVS_WRITE <= w;
		AVS_READ <= !w;
		t = 0;
		do begin
			@(posedge CLK);
			t++;
		end while (AVS_WAITREQUEST !== 1'h0 && t < 20);
		if (AVS_WAITREQUEST !== 1'h0) hang();
		rd = AVS_READDATA;
		AVS_WRITE <= 1'h0;
		AVS_READ <= 1'h0;
		@(posedge CLK);
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		bus(1'h1, a, d);
	endtask
	task automatic rdc(input logic [4:0] a, input logic [31:0] e);
		bus(1'h0, a, 8'h00);
		check(rd, e);
	endtask
	// First edge lets a just-cleared flag settle
	task automatic wait_irq();
		int t;
		@(posedge CLK);
		for (t = 0; t < 2000 && IRQ !== 1'h1; t++) @(posedge CLK);
		if (IRQ !== 1'h1) hang();
	endtask
	// Start fall to stop rise: nine bits of two overflows
	function automatic int frame_clks(input int div, input int rl);
		return 18 * (256 - rl) * div;
	endfunction
	function automatic logic [10:0] exp_frame(input logic [7:0] b,
		input int m);
		return m ? {2'h3, b, 1'h0} : {2'h1, b, 1'h0};
	endfunction
	// ---
	// Scenarios
	// ---
	initial begin
		int n;
		void'($urandom(66425));
		repeat (8) @(posedge CLK);
		SYS_RST <= 1'h0;
		@(posedge CLK);
		// Reset values; unmapped write must vanish
		wr(5'h1C, 8'hFF);
		for (int i = 0; i < 8; i++) begin
			rdc(5'(i * 4), i == 0 ? 32'h40 : 32'h0);
		end
		// Frame length for each timer clock source
		// An all-zero byte keeps the line low from start to stop
		wr(ADDR_RELOAD, 8'hFF);
		for (int s = 0; s < 6; s++) begin
			wr(ADDR_TMR_CTRL, {4'h0, 3'(s), 1'h1});
			wr(ADDR_DATA, 8'h00);
			for (n = 0; n < 3000 && TXD === 1'h1; n++) @(posedge CLK);
			if (TXD !== 1'h0) hang();
			for (n = 0; n < 3000 && TXD === 1'h0; n++) @(posedge CLK);
			check(n, frame_clks(divs[s], 255));
			repeat (200) @(posedge CLK);
		end
		check(IRQ, 1'h0);
		// Overflow at twice the baud rate, 32 clocks a bit
		wr(ADDR_RELOAD, 8'hF0);
		wr(ADDR_TMR_CTRL, 8'h01);
		wr(ADDR_MASK, 8'h03);
		wr(ADDR_STATUS, 8'h03);
		// Transmit in both frame sizes
		for (int m = 0; m < 2; m++) begin
			b0 = 8'($urandom_range(1, 255));
			wr(ADDR_CTRL, m ? 8'h98 : 8'h10);
			wr(ADDR_DATA, b0);
			u_peer.recv(bit_clks, 10 + m, fr, ok);
			if (!ok) hang();
			check(fr, exp_frame(b0, m));
			rdc(ADDR_STATUS, 32'h2);
			check(IRQ, 1'h1);
			rdc(ADDR_DATA, 32'h0);
			wr(ADDR_STATUS, 8'h02);
			rdc(ADDR_STATUS, 32'h0);
			check(IRQ, 1'h0);
		end
		// Back-to-back receive, then overrun while flag set
		// Each byte differs from the one before so every read can trip
		wr(ADDR_CTRL, 8'h10);
		b0 = 8'($urandom_range(1, 255));
		b1 = b0 ^ 8'($urandom_range(1, 255));
		fork
			begin
				repeat ($urandom_range(0, 31)) @(posedge CLK);
				u_peer.send({1'h0, b0}, 1'h0, bit_clks);
				u_peer.send({1'h0, b1}, 1'h0, bit_clks);
				u_peer.send({1'h0, ~b1}, 1'h0, bit_clks);
			end
			begin
				wait_irq();
				rdc(ADDR_DATA, {24'h0, b0});
				wr(ADDR_STATUS, 8'h01);
				wait_irq();
				rdc(ADDR_DATA, {24'h0, b1});
				rdc(ADDR_CTRL, 32'h55);
			end
		join
		rdc(ADDR_DATA, {24'h0, b1});
		// Nine-bit receive with filter: only qualified bytes kept
		wr(ADDR_STATUS, 8'h01);
		wr(ADDR_CTRL, 8'hB0);
		for (int q = 0; q < 2; q++) begin
			b0 = b1 ^ 8'($urandom_range(1, 255));
			repeat ($urandom_range(0, 31)) @(posedge CLK);
			u_peer.send({q[0], b0}, 1'h1, bit_clks);
			repeat (bit_clks) @(posedge CLK);
			rdc(ADDR_STATUS, q);
		end
		rdc(ADDR_DATA, {24'h0, b0});
		rdc(ADDR_CTRL, 32'hF5);
		tally_and_finish();
	end
endmodule
bind ubt_top ubt_sva u_sva (
	.CLK(CLK), .SYS_RST(SYS_RST), .AVS_ADDRESS(AVS_ADDRESS),
	.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
	.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
	.TXD(TXD), .IRQ(IRQ)
);
